// ---- design/i2c_master_data_path.v ----
/*
 * Byte data path of a two-wire bus master: registers on classic
 * Wishbone, start/stop generation, byte shifter and acknowledge handling.
 * Assumes: 100 MHz clk_in; a bit-rate clock from a timer on bit_clk_in,
 * much slower than clk_in; external pull-ups on both bus lines.
 */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`include "i2c_master_map.vh"

module i2c_master_data_path (
   input wire clk_in,
   input wire rst_b_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [31:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   input wire bit_clk_in,
   input wire bus_data_pin_in,
   output wire bus_data_pin_out,
   output wire bus_data_pin_oe_out,
   input wire bus_clock_pin_in,
   output wire bus_clock_pin_out,
   output wire bus_clock_pin_oe_out,
   output reg rx_full_irq_out,
   output reg tx_empty_irq_out
);

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_START = 3'd1;
   localparam [2:0] ST_BITS = 3'd2;
   localparam [2:0] ST_ACK = 3'd3;
   localparam [2:0] ST_HOLD = 3'd4;
   localparam [2:0] ST_STOP = 3'd5;

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   reg master_module_enable;
   reg start_request;
   reg stop_request;
   reg noise_filter;
   reg tx_busy_flag;
   reg rx_busy_flag;
   reg rx_byte_ready_flag;
   reg receive_execute;
   reg transmit_execute;
   reg ack_response_bit;
   reg [7:0] byte_field;
   reg rx_full_irq_enable;
   reg tx_empty_irq_enable;

   // ----------------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------------
   reg [2:0] state;
   reg [1:0] step;
   reg [2:0] bit_count;
   reg [7:0] shifter;
   reg rx_mode;
   reg sda_low;
   reg scl_low;
   reg bit_clk_prev;
   reg tx_empty_event;
   reg rx_full_event;

   wire [2:0] synced;
   wire bit_clk_s;
   wire sda_s;
   wire scl_s;
   wire tick;
   wire bus_req;
   wire wr_now;
   wire rd_now;
   wire [15:0] data_reg_view;
   wire [15:0] data_merged;
   reg [15:0] read_mux;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // byte address of a register index
   function hit;
      input [31:0] adr;
      input [15:0] idx;
      begin
         hit = (adr == {14'h0000, idx, 2'b00});
      end
   endfunction

   // merge one 16-bit register under the byte lane selects
   function [15:0] lanes;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0] sel;
      begin
         lanes = old_val;
         if (sel[0]) begin
            lanes[7:0] = new_val[7:0];
         end
         if (sel[1]) begin
            lanes[15:8] = new_val[15:8];
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // pin inputs and bit-rate clock edges
   // ----------------------------------------------------------------------
   in_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .d_in({bit_clk_in, bus_data_pin_in, bus_clock_pin_in}),
      .q_out(synced)
   );

   assign bit_clk_s = synced[2];
   assign sda_s = synced[1];
   assign scl_s = synced[0];

   // rising edge of the bit-rate clock paces the sequencer
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         bit_clk_prev <= 1'b0;
      end else begin
         bit_clk_prev <= bit_clk_s;
      end
   end

   assign tick = bit_clk_s & ~bit_clk_prev;

   // ----------------------------------------------------------------------
   // open-drain pins
   // ----------------------------------------------------------------------

   // lines are only pulled low or let float
   assign bus_data_pin_out = 1'b0;
   assign bus_clock_pin_out = 1'b0;
   assign bus_data_pin_oe_out = sda_low;
   assign bus_clock_pin_oe_out = scl_low;

   // ----------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------
   assign bus_req = wb_cyc_in & wb_stb_in;
   assign wr_now = bus_req & wb_ack_out & wb_we_in;
   assign rd_now = bus_req & wb_ack_out & ~wb_we_in;

   assign data_reg_view = {4'h0, rx_byte_ready_flag, receive_execute, transmit_execute,
                           ack_response_bit, byte_field};

   // data register as it stands after a write under the lane selects
   assign data_merged = lanes(data_reg_view, wb_dat_in[15:0], wb_sel_in[1:0]);

   // read view of all registers; unmapped reads as zero
   always @* begin
      read_mux = 16'h0000;
      if (hit(wb_adr_in, `IDX_MASTER_ENABLE)) begin
         read_mux[`POS_MASTER_MODULE_ENABLE] = master_module_enable;
      end else if (hit(wb_adr_in, `IDX_MASTER_CONTROL)) begin
         read_mux[`POS_START_REQUEST] = start_request;
         read_mux[`POS_STOP_REQUEST] = stop_request;
         read_mux[`POS_NOISE_FILTER] = noise_filter;
         read_mux[`POS_TX_BUSY_FLAG] = tx_busy_flag;
         read_mux[`POS_RX_BUSY_FLAG] = rx_busy_flag;
      end else if (hit(wb_adr_in, `IDX_MASTER_DATA_AND_EXECUTE)) begin
         read_mux = data_reg_view;
      end else if (hit(wb_adr_in, `IDX_MASTER_INTERRUPT_ENABLES)) begin
         read_mux[`POS_TX_EMPTY_IRQ_ENABLE] = tx_empty_irq_enable;
         read_mux[`POS_RX_FULL_IRQ_ENABLE] = rx_full_irq_enable;
      end
   end

   // one-cycle acknowledge with registered read data
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= bus_req & ~wb_ack_out;
         if (bus_req & ~wb_ack_out & ~wb_we_in) begin
            wb_dat_out <= {16'h0000, read_mux};
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt requests to the interrupt controller
   // ----------------------------------------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_full_irq_out <= 1'b0;
         tx_empty_irq_out <= 1'b0;
      end else begin
         rx_full_irq_out <= rx_full_event & rx_full_irq_enable;
         tx_empty_irq_out <= tx_empty_event & tx_empty_irq_enable;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer and register writes
   // ----------------------------------------------------------------------

   // hardware updates first, software writes after so they take priority
   always @(posedge clk_in) begin : seq
      if (!rst_b_in) begin
         master_module_enable <= `RST_FLAG;
         start_request <= `RST_FLAG;
         stop_request <= `RST_FLAG;
         noise_filter <= `RST_FLAG;
         tx_busy_flag <= `RST_FLAG;
         rx_busy_flag <= `RST_FLAG;
         rx_byte_ready_flag <= `RST_FLAG;
         receive_execute <= `RST_FLAG;
         transmit_execute <= `RST_FLAG;
         ack_response_bit <= `RST_FLAG;
         byte_field <= `RST_BYTE_FIELD;
         rx_full_irq_enable <= `RST_FLAG;
         tx_empty_irq_enable <= `RST_FLAG;
         state <= ST_IDLE;
         step <= 2'd0;
         bit_count <= `RST_BIT_COUNT;
         shifter <= 8'h00;
         rx_mode <= 1'b0;
         sda_low <= 1'b0;
         scl_low <= 1'b0;
         tx_empty_event <= 1'b0;
         rx_full_event <= 1'b0;
      end else begin
         tx_empty_event <= 1'b0;
         rx_full_event <= 1'b0;
         // reading the byte clears ready; a load in the same cycle wins
         if (rd_now & hit(wb_adr_in, `IDX_MASTER_DATA_AND_EXECUTE) & wb_sel_in[0]) begin
            rx_byte_ready_flag <= 1'b0;
         end
         if (!master_module_enable) begin
            // disabled: lines released, transfer dropped
            state <= ST_IDLE;
            step <= 2'd0;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
            tx_busy_flag <= 1'b0;
            rx_busy_flag <= 1'b0;
         end else if (tick) begin
            case (state)
               ST_IDLE: begin
                  // free bus: data low while clock high
                  if (start_request) begin
                     sda_low <= 1'b1;
                     step <= 2'd3;
                     state <= ST_START;
                  end
               end
               ST_START: begin
                  // repeated start releases data, then clock, then pulls data
                  case (step)
                     2'd0: begin
                        sda_low <= 1'b0;
                        step <= 2'd1;
                     end
                     2'd1: begin
                        scl_low <= 1'b0;
                        step <= 2'd2;
                     end
                     2'd2: begin
                        if (scl_s) begin
                           sda_low <= 1'b1;
                           step <= 2'd3;
                        end
                     end
                     default: begin
                        scl_low <= 1'b1;
                        start_request <= 1'b0;
                        state <= ST_HOLD;
                     end
                  endcase
               end
               ST_HOLD: begin
                  // bus owned, clock held low; pending requests picked up here
                  if (start_request) begin
                     step <= 2'd0;
                     state <= ST_START;
                  end else if (transmit_execute) begin
                     shifter <= byte_field;
                     transmit_execute <= 1'b0;
                     tx_empty_event <= 1'b1;
                     tx_busy_flag <= 1'b1;
                     rx_mode <= 1'b0;
                     bit_count <= `RST_BIT_COUNT;
                     step <= 2'd0;
                     state <= ST_BITS;
                  end else if (receive_execute) begin
                     rx_busy_flag <= 1'b1;
                     rx_mode <= 1'b1;
                     bit_count <= `RST_BIT_COUNT;
                     step <= 2'd0;
                     state <= ST_BITS;
                  end else if (stop_request) begin
                     step <= 2'd0;
                     state <= ST_STOP;
                  end
               end
               ST_BITS: begin
                  case (step)
                     2'd0: begin
                        // data set up while clock is low
                        sda_low <= rx_mode ? 1'b0 : ~shifter[7];
                        step <= 2'd1;
                     end
                     2'd1: begin
                        scl_low <= 1'b0;
                        step <= 2'd2;
                     end
                     default: begin
                        // wait out slave clock stretching, then sample
                        if (scl_s) begin
                           scl_low <= 1'b1;
                           shifter <= {shifter[6:0], sda_s};
                           step <= 2'd0;
                           if (rx_mode && bit_count == 3'd7) begin
                              receive_execute <= 1'b0;
                           end
                           if (bit_count == 3'd0) begin
                              state <= ST_ACK;
                              if (rx_mode) begin
                                 byte_field <= {shifter[6:0], sda_s};
                                 rx_byte_ready_flag <= 1'b1;
                                 rx_full_event <= 1'b1;
                              end
                           end else begin
                              bit_count <= bit_count - 3'd1;
                           end
                        end
                     end
                  endcase
               end
               ST_ACK: begin
                  case (step)
                     2'd0: begin
                        sda_low <= rx_mode ? ~ack_response_bit : 1'b0;
                        step <= 2'd1;
                     end
                     2'd1: begin
                        scl_low <= 1'b0;
                        step <= 2'd2;
                     end
                     default: begin
                        if (scl_s) begin
                           scl_low <= 1'b1;
                           if (!rx_mode) begin
                              ack_response_bit <= sda_s;
                           end
                           tx_busy_flag <= 1'b0;
                           rx_busy_flag <= 1'b0;
                           step <= 2'd0;
                           state <= ST_HOLD;
                        end
                     end
                  endcase
               end
               ST_STOP: begin
                  // data low, clock released, then data released
                  case (step)
                     2'd0: begin
                        sda_low <= 1'b1;
                        step <= 2'd1;
                     end
                     2'd1: begin
                        scl_low <= 1'b0;
                        step <= 2'd2;
                     end
                     default: begin
                        if (scl_s) begin
                           sda_low <= 1'b0;
                           stop_request <= 1'b0;
                           step <= 2'd0;
                           state <= ST_IDLE;
                        end
                     end
                  endcase
               end
               default: begin
                  state <= ST_IDLE;
                  step <= 2'd0;
               end
            endcase
         end
         // software writes, accepted at any time
         if (wr_now) begin
            if (hit(wb_adr_in, `IDX_MASTER_ENABLE) & wb_sel_in[0]) begin
               master_module_enable <= wb_dat_in[`POS_MASTER_MODULE_ENABLE];
            end
            if (hit(wb_adr_in, `IDX_MASTER_CONTROL) & wb_sel_in[0]) begin
               start_request <= wb_dat_in[`POS_START_REQUEST];
               stop_request <= wb_dat_in[`POS_STOP_REQUEST];
               noise_filter <= wb_dat_in[`POS_NOISE_FILTER];
            end
            if (hit(wb_adr_in, `IDX_MASTER_DATA_AND_EXECUTE)) begin
               byte_field <= data_merged[`POS_BYTE_FIELD_MSB:`POS_BYTE_FIELD_LSB];
               ack_response_bit <= data_merged[`POS_ACK_RESPONSE_BIT];
               transmit_execute <= data_merged[`POS_TRANSMIT_EXECUTE];
               receive_execute <= data_merged[`POS_RECEIVE_EXECUTE];
            end
            if (hit(wb_adr_in, `IDX_MASTER_INTERRUPT_ENABLES) & wb_sel_in[0]) begin
               tx_empty_irq_enable <= wb_dat_in[`POS_TX_EMPTY_IRQ_ENABLE];
               rx_full_irq_enable <= wb_dat_in[`POS_RX_FULL_IRQ_ENABLE];
            end
         end
      end
   end

endmodule

// ---- design/in_sync.v ----
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes: each bit is a slow level or clock from outside clk_in's
 * domain; only the second stage is read outside.
 */
`timescale 1ns/1ns

module in_sync #(
   parameter WIDTH = 3
) (
   input wire clk_in,
   input wire rst_b_in,
   input wire [WIDTH-1:0] d_in,
   output wire [WIDTH-1:0] q_out
);

   // ----------------------------------------------------------------------
   // synchroniser stages
   // ----------------------------------------------------------------------
   reg [WIDTH-1:0] stage_a;
   reg [WIDTH-1:0] stage_b;

   // first stage feeds only the second
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         stage_a <= {WIDTH{1'b0}};
         stage_b <= {WIDTH{1'b0}};
      end else begin
         stage_a <= d_in;
         stage_b <= stage_a;
      end
   end

   assign q_out = stage_b;

endmodule

// ---- shared/i2c_master_map.vh ----
/*
 * Register map of the two-wire bus master data path: register indices,
 * field positions and reset values.
 * Assumes: included by bare name; a register's byte address is four
 * times its index on a 32-bit classic Wishbone bus.
 */
`ifndef I2C_MASTER_MAP_VH
`define I2C_MASTER_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_MASTER_ENABLE 16'h4340
`define IDX_MASTER_CONTROL 16'h4342
`define IDX_MASTER_DATA_AND_EXECUTE 16'h4344
`define IDX_MASTER_INTERRUPT_ENABLES 16'h4346

// ----------------------------------------------------------------------
// field positions of the enable register
// ----------------------------------------------------------------------
`define POS_MASTER_MODULE_ENABLE 0

// ----------------------------------------------------------------------
// field positions of the control register
// ----------------------------------------------------------------------
`define POS_START_REQUEST 0
`define POS_STOP_REQUEST 1
`define POS_NOISE_FILTER 4
`define POS_TX_BUSY_FLAG 8
`define POS_RX_BUSY_FLAG 9

// ----------------------------------------------------------------------
// field positions of the data and execute register
// ----------------------------------------------------------------------
`define POS_BYTE_FIELD_LSB 0
`define POS_BYTE_FIELD_MSB 7
`define POS_ACK_RESPONSE_BIT 8
`define POS_TRANSMIT_EXECUTE 9
`define POS_RECEIVE_EXECUTE 10
`define POS_RX_BYTE_READY_FLAG 11

// ----------------------------------------------------------------------
// field positions of the interrupt enable register
// ----------------------------------------------------------------------
`define POS_TX_EMPTY_IRQ_ENABLE 0
`define POS_RX_FULL_IRQ_ENABLE 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE_FIELD 8'h00
`define RST_FLAG 1'b0
`define RST_BIT_COUNT 3'h7

`endif

// ---- tb/i2c_master_data_path_checker.sv ----
/* checker for the bus master data path: bus handshake, pins, requests
   assumes: bound to the top module; one clock domain */
`timescale 1ns/1ns
module i2c_master_data_path_checker (
   input wire clk_in,
   input wire rst_b_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire [31:0] wb_dat_out,
   input wire wb_ack_out,
   input wire bus_data_pin_out,
   input wire bus_data_pin_oe_out,
   input wire bus_clock_pin_out,
   input wire bus_clock_pin_oe_out,
   input wire rx_full_irq_out,
   input wire tx_empty_irq_out
);
   // ---------------
   // sequences
   // ---------------
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // a new request, and the data line pulled while the clock line is free
   sequence req_s;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence start_s;
      $rose(bus_data_pin_oe_out) && !bus_clock_pin_oe_out;
   endsequence
   // ---------------
   // assertions
   // ---------------
   AST_ACK_NEXT: assert property (req_s |=> wb_ack_out)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   AST_UPPER_ZERO: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0)
      else $error("upper read data not zero");
   AST_RESET_QUIET: assert property ($rose(rst_b_in) |-> !wb_ack_out && !bus_data_pin_oe_out && !bus_clock_pin_oe_out)
      else $error("outputs active after reset");
   AST_DRIVE_LOW_ONLY: assert property (!bus_data_pin_out && !bus_clock_pin_out)
      else $error("bus pin driven high");
   AST_START_CLOCK: assert property (start_s |-> ##[1:60] bus_clock_pin_oe_out)
      else $error("clock line not pulled after start");
   AST_TX_IRQ_PULSE: assert property (tx_empty_irq_out |=> !tx_empty_irq_out)
      else $error("transmit request not a pulse");
   AST_RX_IRQ_PULSE: assert property (rx_full_irq_out |=> !rx_full_irq_out)
      else $error("receive request not a pulse");
   AST_TX_IRQ_SCL_LOW: assert property (tx_empty_irq_out |-> bus_clock_pin_oe_out)
      else $error("byte loaded while clock line free");
endmodule

bind i2c_master_data_path i2c_master_data_path_checker i2c_master_data_path_checker_i (.clk_in(clk_in),
   .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .bus_data_pin_out(bus_data_pin_out), .bus_data_pin_oe_out(bus_data_pin_oe_out),
   .bus_clock_pin_out(bus_clock_pin_out), .bus_clock_pin_oe_out(bus_clock_pin_oe_out),
   .rx_full_irq_out(rx_full_irq_out), .tx_empty_irq_out(tx_empty_irq_out));

// ---- tb/i2c_slave_model.sv ----
/* slave on the two-wire bus: acks written bytes, sends bytes on reads
   assumes: lines pulled up; sda_low_out high pulls the data line low */
`timescale 1ns/1ns
module i2c_slave_model (
   input wire logic clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic rd_in,
   input wire logic nack_in,
   input wire logic [7:0] byte_in,
   output logic sda_low_out,
   output logic [7:0] got_out,
   output logic got_stb_out
);
   logic scl_q = 1;
   logic sda_q = 1;
   logic [3:0] idx = 4'hf;
   logic [7:0] sh = 8'h00;
   logic [7:0] cur = 8'h00;
   // ---------------
   // wire behaviour
   // ---------------
   // idx moves on a clock fall, or to 15 on a start while the clock is high, which releases data; otherwise data never changes under a high clock
   assign sda_low_out = rd_in ? (idx < 8 && !cur[3'h7 - idx[2:0]]) : (idx == 8 && !nack_in);
   initial got_out = 8'h00;
   initial got_stb_out = 0;
   // start detect, sampling on clock rise, bit count on clock fall
   always @(posedge clk_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      got_stb_out <= 0;
      if (scl_in && scl_q && sda_q && !sda_in) begin
         idx <= 4'hf;
      end else if (scl_in && !scl_q) begin
         sh <= {sh[6:0], sda_in};
         if (idx == 8) begin
            got_out <= rd_in ? {7'h0, sda_in} : sh;
            got_stb_out <= 1;
         end
      end else if (!scl_in && scl_q) begin
         idx <= (idx >= 8) ? 4'h0 : idx + 4'h1;
         if (idx >= 8) cur <= byte_in;
      end
   end
endmodule

// ---- tb/testbench.sv ----
/* self-checking bench for the bus master data path
   assumes: design, slave model and checker are compiled before it */
`timescale 1ns/1ns
`include "i2c_master_map.vh"
module testbench;
   // ---------------
   // signals
   // ---------------
   localparam [15:0] EN = `IDX_MASTER_ENABLE;
   localparam [15:0] CT = `IDX_MASTER_CONTROL;
   localparam [15:0] DT = `IDX_MASTER_DATA_AND_EXECUTE;
   localparam [15:0] IE = `IDX_MASTER_INTERRUPT_ENABLES;
   logic clk_in = 0, rst_b_in = 0, cyc = 0, stb = 0, we = 0, bclk = 0, rd = 0, nack = 0;
   logic [31:0] adr = 0, dat = 0;
   logic [3:0] sel = 0;
   logic [7:0] sbyte = 0, b1, b2, b3, r1, r2;
   logic [15:0] rdat;
   logic [15:0] eq[$], mq[$];
   logic [7:0] gq[$];
   wire sda, scl, sda_oe, scl_oe, slv_low, got_stb, rx_irq, tx_irq, ack;
   wire [31:0] rdo;
   wire [7:0] got;
   integer errors = 0, n_compared = 0, n_tx = 0, n_rx = 0, cyc_n = 0, seed;
   // wired-and lines with pull-ups, system and bit-rate clocks
   assign sda = !(sda_oe || slv_low);
   assign scl = !scl_oe;
   always #5 clk_in = !clk_in;
   always begin
      #63 bclk = 1;
      #62 bclk = 0;
   end
   i2c_master_data_path i2c_master_data_path_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdo),
      .wb_ack_out(ack), .bit_clk_in(bclk), .bus_data_pin_in(sda), .bus_data_pin_out(),
      .bus_data_pin_oe_out(sda_oe), .bus_clock_pin_in(scl), .bus_clock_pin_out(),
      .bus_clock_pin_oe_out(scl_oe), .rx_full_irq_out(rx_irq), .tx_empty_irq_out(tx_irq));
   i2c_slave_model i2c_slave_model_i (.clk_in(clk_in), .scl_in(scl), .sda_in(sda), .rd_in(rd),
      .nack_in(nack), .byte_in(sbyte), .sda_low_out(slv_low), .got_out(got), .got_stb_out(got_stb));
   // ---------------
   // tasks
   // ---------------
   task check(input logic [15:0] s, input logic [15:0] e, input string nm);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // one classic cycle; a nonzero mask notes the expected read
   task wb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] e, input logic [15:0] m);
      begin
         @(posedge clk_in);
         if (m != 0) begin
            eq.push_back(e);
            mq.push_back(m);
         end
         cyc <= 1;
         stb <= 1;
         we <= w;
         adr <= {14'h0, a, 2'h0};
         dat <= {16'h0, d};
         sel <= 4'h3;
         @(posedge clk_in);
         while (ack !== 1'b1) @(posedge clk_in);
         rdat = rdo[15:0];
         cyc <= 0;
         stb <= 0;
      end
   endtask
   // read until the masked bits are clear
   task poll(input logic [15:0] a, input logic [15:0] m);
      begin
         rdat = m;
         while ((rdat & m) != 0) wb(0, a, 0, 0, 0);
      end
   endtask
   task end_sim;
      begin
         if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ---------------
   // watcher
   // ---------------
   // compares read data and slave bytes against the oldest note, counts requests
   always @(posedge clk_in) begin
      if (ack === 1'b1 && !we && eq.size() > 0) begin
         check(rdo[15:0] & mq[0], eq[0], "read data");
         eq.pop_front();
         mq.pop_front();
      end
      if (got_stb === 1'b1 && gq.size() > 0) begin
         check({8'h0, got}, {8'h0, gq[0]}, "bus byte");
         gq.pop_front();
      end
      if (tx_irq === 1'b1) n_tx <= n_tx + 1;
      if (rx_irq === 1'b1) n_rx <= n_rx + 1;
      cyc_n <= cyc_n + 1;
      if (cyc_n > 20000) begin
         errors = errors + 1;
         end_sim;
      end
   end
   // ---------------
   // sequence
   // ---------------
   initial begin
      seed = $urandom(5);
      {b1, b2, b3, r1} = $urandom;
      r2 = 8'($urandom);
      sbyte = r1;
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1;
      for (int i = 0; i < 5; i++) wb(0, EN + 2 * i, 0, 0, 16'hffff);
      wb(1, IE, 16'h0003, 0, 0);
      wb(0, IE, 0, 16'h0003, 16'hffff);
      wb(1, DT, {8'h02, b1}, 0, 0);
      gq.push_back(b1);
      repeat (100) @(posedge clk_in);
      wb(0, DT, 0, {8'h02, b1}, 16'h0fff);
      check({14'h0, sda_oe, scl_oe}, 0, "lines while off");
      wb(1, CT, 16'h0001, 0, 0);
      wb(1, EN, 16'h0001, 0, 0);
      while (n_tx < 1) @(posedge clk_in);
      wb(0, DT, 0, 0, 16'h0200);
      wb(1, DT, {8'h02, b2}, 0, 0);
      gq.push_back(b2);
      while (n_tx < 2) @(posedge clk_in);
      nack <= 1;
      poll(CT, 16'h0100);
      wb(0, DT, 0, 16'h0100, 16'h0300);
      rd <= 1;
      gq.push_back(0);
      gq.push_back(1);
      wb(1, DT, 16'h0400, 0, 0);
      poll(DT, 16'h0400);
      wb(1, DT, 16'h0400, 0, 0);
      while (n_rx < 1) @(posedge clk_in);
      sbyte <= r2;
      poll(DT, 16'h0400);
      wb(1, DT, 16'h0100, 0, 0);
      while (n_rx < 2) @(posedge clk_in);
      poll(CT, 16'h0200);
      wb(0, DT, 0, {8'h09, r2}, 16'h0fff);
      wb(0, DT, 0, 0, 16'h0800);
      check(n_rx[15:0], 2, "receive requests");
      rd <= 0;
      wb(1, IE, 0, 0, 0);
      wb(1, DT, {8'h02, b3}, 0, 0);
      gq.push_back(b3);
      // repeated start and stop queued together; start and byte go first
      wb(1, CT, 16'h0003, 0, 0);
      poll(CT, 16'h0303);
      repeat (40) @(posedge clk_in);
      wb(0, CT, 0, 0, 16'hffff);
      check({14'h0, sda_oe, scl_oe}, 0, "lines after stop");
      check(n_tx[15:0], 2, "transmit requests");
      end_sim;
   end
endmodule
